// File: rtl/lcd_host_port.sv
// host-side parallel and serial interface of a bit-map display driver
`include "host_port_defs.svh"
// Function
// [R1] strap high selects parallel bus; low selects serial on bits 7 and 6
// [R2] serial mode has no read path at all
// [R3] style pin high: enable plus r/w line; low: separate low strobes
// [R4] data/command select and direction decode the four access kinds
// [R5] 8-bit shifter and 3-bit counter cleared while chip select is high
// [R6] serial data msb first, one bit per rising serial clock
// [R7] eighth rising serial clock hands on the byte
// [R8] data/command select sampled at every eighth serial clock edge
// [R9] partial serial byte at deselect or reset is handed on as command
// [R10] host sends only whole bytes before deselect or reset; the bench also sends 3-bit partial bytes to test R9
// [R11] data read returns held word and loads freshly fetched word
// [R12] data write is held then committed on the next write
// [R13] host makes one dummy read after address set or write
// [R14] host keeps the bus cycle time, padding with idle operations
// [R15] device responds only while chip select is low
// [R16] deselected: data pins released, all other inputs but reset ignored
// [R17] reset acts regardless of chip select
// [R18] data pins driven only during a selected parallel read strobe
module lcd_host_port
(
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // straps and controls from pins
  input wire logic PAR_SEL_IN,
  input wire logic BUS_STYLE_SELECT_IN,
  input wire logic CHIP_SEL_N_IN,
  input wire logic DATA_COMMAND_SELECT_IN,
  input wire logic RD_STROBE_IN,
  input wire logic WR_STROBE_IN,
  input wire logic HARD_CLEAR_N_IN,
  // data pins
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic [7:0] DATA_OE_OUT,
  // towards instruction decoder and display memory
  output logic CMD_VALID_OUT,
  output logic CMD_IS_DATA_OUT,
  output logic [7:0] CMD_BYTE_OUT,
  output logic MEM_WR_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  output logic MEM_RD_OUT,
  input wire logic [7:0] MEM_RDATA_IN,
  output logic STATUS_RD_OUT,
  input wire logic [7:0] STATUS_IN
);
  import host_port_pkg::*;

  // two-stage synchronisers for every pin
  localparam int NS = 7;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_ff;
  logic [NS-1:0] sync2_ff;
  logic [7:0] d1_ff;
  logic [7:0] d2_ff;
  assign pin_raw = {PAR_SEL_IN, BUS_STYLE_SELECT_IN, CHIP_SEL_N_IN,
    DATA_COMMAND_SELECT_IN, RD_STROBE_IN, WR_STROBE_IN, HARD_CLEAR_N_IN};
  always_ff @(posedge SYS_CLK_IN)
  begin
    sync1_ff <= pin_raw;
    sync2_ff <= sync1_ff;
    d1_ff <= DATA_IN;
    d2_ff <= d1_ff;
  end

  wire par_mode = sync2_ff[6];
  wire style_e = sync2_ff[5];
  wire cs_act = ~sync2_ff[4];
  wire dc_sel = sync2_ff[3];
  wire rd_pin = sync2_ff[2];
  wire wr_pin = sync2_ff[1];
  // [R17] hard clear is honoured whatever chip select does
  wire clr = SYS_RST_IN | ~sync2_ff[0];

  // [R3] strobe active in each bus style
  wire strobe = style_e ? rd_pin : (~rd_pin | ~wr_pin);
  wire is_read = style_e ? wr_pin : ~rd_pin;
  // [R15] [R16] [R1] parallel access only while selected in parallel mode
  wire par_act = par_mode & cs_act & strobe;
  logic par_act_ff;
  logic rd_acc_ff;
  wire par_start = par_act & ~par_act_ff;
  // [R4] access kind decode
  wire access_t acc = access_t'({dc_sel, ~is_read});

  // [R6] serial clock edge detection on synchronised pin
  logic scl_ff;
  wire scl = d2_ff[`SCL_BIT];
  wire ser_en = ~par_mode & cs_act;
  wire scl_rise = ser_en & scl & ~scl_ff;
  logic [7:0] shift_ff;
  logic [2:0] cnt_ff;
  wire [7:0] nxt_shift = {shift_ff[6:0], d2_ff[`SI_BIT]};
  wire byte_done = scl_rise & (cnt_ff == `BIT_CNT_LAST);
  // [R9] dropping chip select mid-byte flushes a command
  logic cs_act_ff;
  wire partial = (cnt_ff != `BIT_CNT_INIT) & ~par_mode &
    ((cs_act_ff & ~cs_act) | clr);

  logic [7:0] hold_ff;
  logic wr_pend_ff;

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      par_act_ff <= 1'b0;
      rd_acc_ff <= 1'b0;
      // track the pin through reset so an idle-high clock gives no false edge
      scl_ff <= scl;
      cs_act_ff <= 1'b0;
    end
    else
    begin
      par_act_ff <= par_act;
      rd_acc_ff <= par_act & is_read;
      scl_ff <= scl;
      cs_act_ff <= cs_act;
    end
  end

  // serial receiver
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (clr | ~ser_en)
    begin
      shift_ff <= `BYTE_ZERO; // [R5]
      cnt_ff <= `BIT_CNT_INIT; // [R5]
    end
    else if (scl_rise)
    begin
      shift_ff <= nxt_shift; // [R6]
      cnt_ff <= cnt_ff + 3'h1;
    end
  end

  // command stream and memory side
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      CMD_VALID_OUT <= 1'b0;
      CMD_IS_DATA_OUT <= 1'b0;
      CMD_BYTE_OUT <= `BYTE_ZERO;
      MEM_WR_OUT <= 1'b0;
      MEM_WDATA_OUT <= `BYTE_ZERO;
      MEM_RD_OUT <= 1'b0;
      STATUS_RD_OUT <= 1'b0;
      hold_ff <= `BYTE_ZERO;
      wr_pend_ff <= 1'b0;
      DATA_OUT <= `BYTE_ZERO;
    end
    else
    begin
      CMD_VALID_OUT <= 1'b0;
      MEM_WR_OUT <= 1'b0;
      MEM_RD_OUT <= 1'b0;
      STATUS_RD_OUT <= 1'b0;
      if (byte_done)
      begin
        CMD_VALID_OUT <= 1'b1; // [R7]
        CMD_IS_DATA_OUT <= dc_sel; // [R8]
        CMD_BYTE_OUT <= nxt_shift; // [R7]
        // serial data bytes commit through the same holder
        if (dc_sel)
        begin
          MEM_WR_OUT <= wr_pend_ff;
          MEM_WDATA_OUT <= hold_ff;
          hold_ff <= nxt_shift;
          wr_pend_ff <= 1'b1;
        end
      end
      else if (partial)
      begin
        CMD_VALID_OUT <= 1'b1; // [R9]
        CMD_IS_DATA_OUT <= 1'b0;
        CMD_BYTE_OUT <= shift_ff;
      end
      else if (par_start)
      begin
        unique case (acc)
          ACC_DATA_RD:
          begin
            // [R11] previous held word goes out, fresh fetch is held
            DATA_OUT <= hold_ff;
            hold_ff <= MEM_RDATA_IN;
            MEM_RD_OUT <= 1'b1;
            wr_pend_ff <= 1'b0;
          end
          ACC_DATA_WR:
          begin
            // [R12] commit earlier byte, hold the new one
            MEM_WR_OUT <= wr_pend_ff;
            MEM_WDATA_OUT <= hold_ff;
            hold_ff <= d2_ff;
            wr_pend_ff <= 1'b1;
            CMD_VALID_OUT <= 1'b1;
            CMD_IS_DATA_OUT <= 1'b1;
            CMD_BYTE_OUT <= d2_ff;
          end
          ACC_STATUS_RD:
          begin
            DATA_OUT <= STATUS_IN;
            STATUS_RD_OUT <= 1'b1;
          end
          ACC_INSTR_WR:
          begin
            CMD_VALID_OUT <= 1'b1;
            CMD_IS_DATA_OUT <= 1'b0;
            CMD_BYTE_OUT <= d2_ff;
          end
        endcase
      end
    end
  end

  // [R18] [R2] [R16] drive only inside a selected parallel read strobe
  wire drive = par_act & is_read & rd_acc_ff;
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      DATA_OE_OUT <= `BYTE_ZERO;
    else
      DATA_OE_OUT <= drive ? `OE_ALL : `BYTE_ZERO;
  end

  // checks
  property p_no_drive_serial;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      !par_mode |=> (DATA_OE_OUT == `BYTE_ZERO);
  endproperty
  a_no_drive_serial: assert property (p_no_drive_serial) // [R2]
    else $error("data pins driven in serial mode");
  property p_desel_release;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      !cs_act |=> (DATA_OE_OUT == `BYTE_ZERO);
  endproperty
  a_desel_release: assert property (p_desel_release) // [R16]
    else $error("data pins driven while deselected");
  property p_cnt_clear;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      !cs_act |=> (cnt_ff == `BIT_CNT_INIT);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) // [R5]
    else $error("bit counter not cleared on deselect");
  property p_byte_out;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      byte_done |=> CMD_VALID_OUT && CMD_BYTE_OUT == $past(nxt_shift);
  endproperty
  a_byte_out: assert property (p_byte_out) // [R7]
    else $error("serial byte not handed on");
  property p_dc_sample;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      byte_done |=> CMD_IS_DATA_OUT == $past(dc_sel);
  endproperty
  a_dc_sample: assert property (p_dc_sample) // [R8]
    else $error("data/command flag wrong");
  property p_shift;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      scl_rise && !clr && cnt_ff != `BIT_CNT_LAST |=>
        shift_ff[0] == $past(d2_ff[`SI_BIT]);
  endproperty
  a_shift: assert property (p_shift) // [R6]
    else $error("serial bit not shifted in");
  property p_rd_hold;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      par_start && acc == ACC_DATA_RD |=> DATA_OUT == $past(hold_ff)
        && hold_ff == $past(MEM_RDATA_IN);
  endproperty
  a_rd_hold: assert property (p_rd_hold) // [R11]
    else $error("read holder order wrong");
  property p_wr_hold;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      par_start && acc == ACC_DATA_WR |=> hold_ff == $past(d2_ff)
        && MEM_WDATA_OUT == $past(hold_ff);
  endproperty
  a_wr_hold: assert property (p_wr_hold) // [R12]
    else $error("write holder order wrong");
  property p_hard_clear;
    @(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      !sync2_ff[0] |=> cnt_ff == `BIT_CNT_INIT;
  endproperty
  a_hard_clear: assert property (p_hard_clear) // [R17]
    else $error("hard clear ignored");
  c_ser_byte: cover property (@(posedge SYS_CLK_IN) byte_done);
  c_par_rd: cover property (@(posedge SYS_CLK_IN)
    par_start && acc == ACC_DATA_RD);
  c_par_wr: cover property (@(posedge SYS_CLK_IN)
    par_start && acc == ACC_DATA_WR);
  c_partial: cover property (@(posedge SYS_CLK_IN) partial);
endmodule

// File: rtl/host_port_defs.svh
// constants for the display driver host port
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH
`define BITS_PER_BYTE 4'h8
`define BIT_CNT_LAST 3'h7
`define BIT_CNT_INIT 3'h0
`define SI_BIT 7
`define SCL_BIT 6
`define BYTE_ZERO 8'h00
`define OE_ALL 8'hff
`endif

// File: rtl/host_port_pkg.sv
// types for the display driver host port
`include "host_port_defs.svh"
package host_port_pkg;
  typedef enum logic [1:0] {
    ACC_STATUS_RD = 2'b00,
    ACC_INSTR_WR = 2'b01,
    ACC_DATA_RD = 2'b10,
    ACC_DATA_WR = 2'b11
  } access_t;
endpackage

// File: dv/mpu_model.sv
// host processor model that drives the display driver bus pins
module mpu_model
(
  // clock and mode
  input wire logic clk_in,
  input wire logic style_in,
  // bus pins
  output logic cs_n_out,
  output logic dc_out,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] data_out,
  input wire logic [7:0] bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wdat = 8'h00;
  logic [7:0] msk = 8'h00;
  // released lines show the inverse of the last value, never a stale copy
  assign data_out = (wdat & msk) | (~wdat & ~msk);
  initial
  begin
    cs_n_out = 1'b1;
    dc_out = 1'b0;
    rd_out = 1'b1;
    wr_out = 1'b1;
  end
  task automatic access(input logic sel, input logic rd, input logic dc,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    cs_n_out <= !sel;
    dc_out <= dc;
    wdat <= d;
    msk <= rd ? 8'h00 : 8'hff;
    rd_out <= !style_in;
    repeat (2) @(posedge clk_in);
    rd_out <= style_in | !rd;
    wr_out <= rd;
    // strobe held well past the sync delay so the cycle time is kept
    repeat (8) @(posedge clk_in);
    q = bus_in;
    rd_out <= !style_in;
    wr_out <= 1'b1;
    msk <= 8'h00;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
  // partial bytes are sent only when a scenario asks for them
  task automatic ser(input logic dc, input logic [7:0] d, input int nb,
    input logic rel);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    msk <= 8'hc0;
    for (int i = 7; i > 7 - nb; i--)
    begin
      wdat <= {d[i], 7'h00};
      dc_out <= (i == 0) ? dc : !dc;
      repeat (5) @(posedge clk_in);
      wdat[6] <= 1'b1;
      repeat (5) @(posedge clk_in);
    end
    wdat <= 8'h00;
    repeat (5) @(posedge clk_in);
    cs_n_out <= rel;
    // clock line is let go only after deselect, so no stray edge
    repeat (3) @(posedge clk_in);
    msk <= rel ? 8'h00 : 8'hc0;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the display driver host port
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, par, style, clr_n;
  logic cs_n, dc, rd, wr;
  logic [7:0] host_d, pins, dout, oe, wdata, cbyte, rdat, stat, q;
  logic cval, cdat, mwr, mrd, srd, cmd_d, oe_seen;
  logic [7:0] cmd_n, cmd_b, wr_n, wr_b, st_n, rd_n;
  int failures = 0;
  int n_compared = 0;
  assign pins = (dout & oe) | (host_d & ~oe);
  lcd_host_port u_dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .PAR_SEL_IN(par),
    .BUS_STYLE_SELECT_IN(style), .CHIP_SEL_N_IN(cs_n),
    .DATA_COMMAND_SELECT_IN(dc), .RD_STROBE_IN(rd), .WR_STROBE_IN(wr),
    .HARD_CLEAR_N_IN(clr_n), .DATA_IN(pins), .DATA_OUT(dout),
    .DATA_OE_OUT(oe), .CMD_VALID_OUT(cval), .CMD_IS_DATA_OUT(cdat),
    .CMD_BYTE_OUT(cbyte), .MEM_WR_OUT(mwr), .MEM_WDATA_OUT(wdata),
    .MEM_RD_OUT(mrd), .MEM_RDATA_IN(rdat), .STATUS_RD_OUT(srd),
    .STATUS_IN(stat));
  mpu_model u_host (.clk_in(clk), .style_in(style), .cs_n_out(cs_n),
    .dc_out(dc), .rd_out(rd), .wr_out(wr), .data_out(host_d), .bus_in(pins));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (cval)
      {cmd_n, cmd_d, cmd_b} = {cmd_n + 8'd1, cdat, cbyte};
    if (mwr)
      {wr_n, wr_b} = {wr_n + 8'd1, wdata};
    if (srd)
      st_n = st_n + 8'd1;
    if (mrd)
      rd_n = rd_n + 8'd1;
    oe_seen = oe_seen | (|oe);
  end
  task automatic chk(input logic [7:0] n, input logic d, input logic [7:0] b);
    `CHK(cmd_n, n)
    `CHK(cmd_d, d)
    `CHK(cmd_b, b)
  endtask
  task automatic test_done;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    {rst, par, style, clr_n, rdat, stat} = {4'b1101, 16'h0000};
    {cmd_n, wr_n, st_n, rd_n, cmd_d, cmd_b, oe_seen} = 42'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    u_host.access(1, 0, 0, 8'h5A, q);
    chk(1, 0, 8'h5A);
    u_host.access(1, 0, 1, 8'hA1, q);
    u_host.access(1, 0, 1, 8'hB2, q);
    chk(3, 1, 8'hB2);
    `CHK({wr_n, wr_b}, {8'd1, 8'hA1})
    stat <= 8'h3C;
    u_host.access(1, 1, 0, 8'h00, q);
    `CHK({st_n, q}, {8'd1, 8'h3C})
    rdat <= 8'h11;
    u_host.access(1, 1, 1, 8'h00, q);
    `CHK(q, 8'hB2)
    rdat <= 8'h22;
    u_host.access(1, 1, 1, 8'h00, q);
    `CHK(q, 8'h11)
    `CHK(rd_n, 8'd2)
    `CHK(oe_seen, 1'b1)
    `CHK(oe, 8'h00)
    $display("parallel strobe test done");
    style <= 1'b1;
    u_host.access(1, 0, 0, 8'hC3, q);
    chk(4, 0, 8'hC3);
    u_host.access(1, 1, 1, 8'h00, q);
    `CHK(q, 8'h22)
    oe_seen = 1'b0;
    u_host.access(0, 0, 0, 8'h77, q);
    u_host.access(0, 1, 1, 8'h00, q);
    chk(4, 0, 8'hC3);
    `CHK(oe_seen, 1'b0)
    $display("enable style and deselect test done");
    par <= 1'b0;
    repeat (4) @(posedge clk);
    u_host.ser(1, 8'hA5, 8, 1);
    chk(5, 1, 8'hA5);
    u_host.ser(0, 8'h3C, 8, 1);
    chk(6, 0, 8'h3C);
    u_host.access(1, 1, 1, 8'h00, q);
    `CHK(oe_seen, 1'b0)
    `CHK(rd_n, 8'd3)
    u_host.ser(0, 8'hA0, 3, 1);
    chk(7, 0, 8'h05);
    u_host.ser(1, 8'h96, 8, 1);
    chk(8, 1, 8'h96);
    $display("serial test done");
    u_host.ser(1, 8'hE0, 3, 0);
    clr_n <= 1'b0;
    repeat (6) @(posedge clk);
    clr_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(9, 0, 8'h07);
    u_host.ser(1, 8'h00, 0, 1);
    `CHK(cmd_n, 8'd9)
    $display("hard clear test done");
    test_done();
  end
  initial
  begin
    repeat (8000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule
